// ==== core/tcw_timer8.v ====
`timescale 1ns/100ps
`default_nettype none
`include "tcw_defines.vh"
module tcw_timer8 (
	// clock and reset
	input  wire        core_clk,
	input  wire        rstn,
	// wishbone slave
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [3:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	output wire        wb_err_o,
	// interrupt service acknowledge
	input  wire        ovfServiced,
	input  wire        cmpServiced,
	// compare output pin
	input  wire        pinIn,
	output wire        pinOut,
	output wire        pinOe,
	// flags and state
	output wire        overflowFlag,
	output wire        compareFlag,
	output wire        compareOutput
);
	reg  [1:0]  waveformMode_r;
	reg  [1:0]  compareOutputMode_r;
	reg  [2:0]  clkSel_r;
	reg  [7:0]  counterValue_r;
	reg  [7:0]  compareValue_r;
	reg  [7:0]  compareBuf_r;
	reg         ovf_r;
	reg         cmp_r;
	reg         oc_r;
	reg         portData_r;
	reg         portDir_r;
	reg         blockMatch_r;
	reg         matchPend_r;
	reg  [9:0]  pre_r;
	reg         pin1_r;
	reg         pin2_r;
	reg         tick;
	wire        isPwm;
	wire        wbReq;
	wire        wrEn;
	wire        wrCount;
	wire        wrCompare;
	wire        wrCtrl;
	wire        forceMatch;
	wire        match;
	wire        atMax;
	wire        ocAtMatch;

	// prescaler taps: 1, 8, 32, 64, 128, 256, 1024
	function prescTap;
		input [2:0]  sel;
		input [9:0]  cnt;
		begin
			case (sel)
				3'h1: prescTap = 1'b1;
				3'h2: prescTap = (cnt[2:0] == 3'h7);
				3'h3: prescTap = (cnt[4:0] == 5'h1F);
				3'h4: prescTap = (cnt[5:0] == 6'h3F);
				3'h5: prescTap = (cnt[6:0] == 7'h7F);
				3'h6: prescTap = (cnt[7:0] == 8'hFF);
				3'h7: prescTap = (cnt == 10'h3FF);
				default: prescTap = 1'b0;
			endcase
		end
	endfunction

	// waveform action on a match, per mode
	function ocOnMatch;
		input [1:0] wgm;
		input [1:0] com;
		input       oc;
		begin
			if (wgm == `TCW_WGM_FAST || wgm == `TCW_WGM_PHASE) begin
				case (com)
					2'h1: ocOnMatch = ~oc;
					2'h2: ocOnMatch = 1'b0;
					2'h3: ocOnMatch = 1'b1;
					default: ocOnMatch = oc;
				endcase
			end else begin
				case (com)
					2'h1: ocOnMatch = ~oc;
					2'h2: ocOnMatch = 1'b0;
					2'h3: ocOnMatch = 1'b1;
					default: ocOnMatch = oc;
				endcase
			end
		end
	endfunction

	assign isPwm     = (waveformMode_r == `TCW_WGM_FAST) || (waveformMode_r == `TCW_WGM_PHASE);
	assign wbReq     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wrEn      = wbReq & wb_we_i;
	assign wrCtrl    = wrEn & (wb_adr_i == `TCW_ADR_CTRL) & wb_sel_i[1] & wb_sel_i[0];
	assign wrCount   = wrEn & (wb_adr_i == `TCW_ADR_COUNT) & wb_sel_i[0];
	assign wrCompare = wrEn & (wb_adr_i == `TCW_ADR_COMPARE) & wb_sel_i[0];
	assign forceMatch = wrCtrl & wb_dat_i[`TCW_CTRL_FORCE] & ~isPwm;
	assign match     = (counterValue_r == compareValue_r) & ~blockMatch_r;
	assign atMax     = (counterValue_r == `TCW_MAX);
	assign ocAtMatch = ocOnMatch(waveformMode_r, compareOutputMode_r, oc_r);
	assign wb_err_o  = 1'b0;

	// override by mode bits only, direction from port bit
	assign pinOut        = (compareOutputMode_r != 2'h0) ? oc_r : portData_r;
	assign pinOe         = portDir_r;
	assign overflowFlag  = ovf_r;
	assign compareFlag   = cmp_r;
	assign compareOutput = oc_r;

	// pin read-back through two stages
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pin1_r <= 1'b0;
			pin2_r <= 1'b0;
		end else begin
			pin1_r <= pinIn;
			pin2_r <= pin1_r;
		end
	end

	// free-running prescaler
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pre_r <= 10'h000;
			tick  <= 1'b0;
		end else begin
			pre_r <= pre_r + 10'h001;
			tick  <= prescTap(clkSel_r, pre_r);
		end
	end

	// control and port registers
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			waveformMode_r      <= `TCW_WGM_NORMAL;
			compareOutputMode_r <= 2'h0;
			clkSel_r            <= 3'h0;
			portData_r          <= 1'b0;
			portDir_r           <= 1'b0;
		end else begin
			if (wrCtrl) begin
				waveformMode_r      <= wb_dat_i[`TCW_CTRL_WGM_LSB +: 2];
				compareOutputMode_r <= wb_dat_i[`TCW_CTRL_COM_LSB +: 2];
				clkSel_r            <= wb_dat_i[`TCW_CTRL_CS_LSB +: 3];
			end
			if (wrEn && wb_adr_i == `TCW_ADR_PORT && wb_sel_i[0]) begin
				portData_r <= wb_dat_i[`TCW_PORT_DATA];
				portDir_r  <= wb_dat_i[`TCW_PORT_DIR];
			end
		end
	end

	// counter, compare registers, waveform state
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			counterValue_r <= `TCW_BOTTOM;
			compareValue_r <= 8'h00;
			compareBuf_r   <= 8'h00;
			blockMatch_r   <= 1'b0;
			matchPend_r    <= 1'b0;
			oc_r           <= 1'b0;
		end else begin
			if (wrCompare) begin
				compareBuf_r <= wb_dat_i[7:0];
				if (!isPwm)
					compareValue_r <= wb_dat_i[7:0];
			end
			if (wrCount) begin
				// cpu write wins over count; blocks next match
				counterValue_r <= wb_dat_i[7:0];
				blockMatch_r   <= 1'b1;
			end else if (tick) begin
				blockMatch_r <= 1'b0;
				matchPend_r  <= match;
				case (waveformMode_r)
					`TCW_WGM_CLEAR: begin
						if (match)
							counterValue_r <= `TCW_BOTTOM;
						else
							counterValue_r <= counterValue_r + 8'h01;
					end
					`TCW_WGM_FAST: begin
						counterValue_r <= atMax ? `TCW_BOTTOM : counterValue_r + 8'h01;
					end
					default: begin
						counterValue_r <= counterValue_r + 8'h01;
					end
				endcase
				if (isPwm && atMax && !wrCompare)
					compareValue_r <= compareBuf_r;
			end
			// pending match held until the next tick, whatever the prescale
			if (forceMatch)
				oc_r <= ocOnMatch(waveformMode_r, wb_dat_i[`TCW_CTRL_COM_LSB +: 2], oc_r);
			else if (tick && !wrCount && match)
				oc_r <= ocAtMatch;
			else if (tick && !wrCount && waveformMode_r == `TCW_WGM_FAST && atMax)
				oc_r <= (compareOutputMode_r == 2'h2) ? 1'b1 :
					(compareOutputMode_r == 2'h3) ? 1'b0 : oc_r;
		end
	end

	// flags: hardware set beats service or software clear
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ovf_r <= 1'b0;
			cmp_r <= 1'b0;
		end else begin
			if (tick && !wrCount && atMax && waveformMode_r != `TCW_WGM_PHASE)
				ovf_r <= 1'b1;
			else if (ovfServiced)
				ovf_r <= 1'b0;
			else if (wrEn && wb_adr_i == `TCW_ADR_FLAGS && wb_sel_i[0] && wb_dat_i[`TCW_FLAG_OVF])
				ovf_r <= 1'b0;
			if (tick && matchPend_r)
				cmp_r <= 1'b1;
			else if (cmpServiced)
				cmp_r <= 1'b0;
			else if (wrEn && wb_adr_i == `TCW_ADR_FLAGS && wb_sel_i[0] && wb_dat_i[`TCW_FLAG_CMP])
				cmp_r <= 1'b0;
		end
	end

	// bus answer: ack one cycle after request, zero for unmapped
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wbReq;
			if (wbReq && !wb_we_i) begin
				case (wb_adr_i)
					`TCW_ADR_CTRL:    wb_dat_o <= {19'h0_0000, 1'b0, 1'b0, clkSel_r,
						2'h0, compareOutputMode_r, 2'h0, waveformMode_r};
					`TCW_ADR_COUNT:   wb_dat_o <= {24'h00_0000, counterValue_r};
					`TCW_ADR_COMPARE: wb_dat_o <= {24'h00_0000, isPwm ? compareBuf_r : compareValue_r};
					`TCW_ADR_FLAGS:   wb_dat_o <= {29'h0000_0000, oc_r, cmp_r, ovf_r};
					`TCW_ADR_PORT:    wb_dat_o <= {29'h0000_0000, pin2_r, portDir_r, portData_r};
					default:          wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ==== core/tcw_defines.vh ====
`ifndef TCW_DEFINES_VH
`define TCW_DEFINES_VH
`define TCW_ADR_CTRL      4'h0
`define TCW_ADR_COUNT     4'h1
`define TCW_ADR_COMPARE   4'h2
`define TCW_ADR_FLAGS     4'h3
`define TCW_ADR_PORT      4'h4
`define TCW_CTRL_WGM_LSB  0
`define TCW_CTRL_COM_LSB  4
`define TCW_CTRL_CS_LSB   8
`define TCW_CTRL_FORCE    12
`define TCW_FLAG_OVF      0
`define TCW_FLAG_CMP      1
`define TCW_PORT_DATA     0
`define TCW_PORT_DIR      1
`define TCW_WGM_NORMAL    2'h0
`define TCW_WGM_PHASE     2'h1
`define TCW_WGM_CLEAR     2'h2
`define TCW_WGM_FAST      2'h3
`define TCW_MAX           8'hFF
`define TCW_BOTTOM        8'h00
`define TCW_PRE_W         10
`endif

// ==== dv/tcw_timer8_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
module tcw_timer8_checker (
	// clock and reset
	input wire logic        core_clk,
	input wire logic        rstn,
	// bus
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [3:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        wb_err_o,
	// service and pin
	input wire logic        ovfServiced,
	input wire logic        cmpServiced,
	input wire logic        pinIn,
	input wire logic        pinOut,
	input wire logic        pinOe,
	input wire logic        overflowFlag,
	input wire logic        compareFlag,
	input wire logic        compareOutput
);
	logic [1:0] comSh_r;
	logic       datSh_r;
	logic       dirSh_r;
	wire        take;
	wire        wrTake;
	wire        ovfClr;
	wire        cmpClr;
	assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wrTake = take & wb_we_i & wb_sel_i[0];
	assign ovfClr = ovfServiced | (wrTake & (wb_adr_i == 4'h3) & wb_dat_i[0]);
	assign cmpClr = cmpServiced | (wrTake & (wb_adr_i == 4'h3) & wb_dat_i[1]);
	// shadow of the bits that steer the pin, taken at the write edge
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			comSh_r <= 2'h0;
			datSh_r <= 1'b0;
			dirSh_r <= 1'b0;
		end else if (wrTake && wb_adr_i == 4'h0) begin
			comSh_r <= wb_dat_i[5:4];
		end else if (wrTake && wb_adr_i == 4'h4) begin
			datSh_r <= wb_dat_i[0];
			dirSh_r <= wb_dat_i[1];
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	ack_after_take_a: assert property (take |=> wb_ack_o) else $error("ack missing");
	ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	err_quiet_a: assert property (!wb_err_o) else $error("err raised");
	pin_dir_a: assert property (pinOe == dirSh_r) else $error("pin enable wrong");
	pin_value_a: assert property (pinOut == (comSh_r != 2'h0 ? compareOutput : datSh_r))
		else $error("pin value wrong");
	ovf_clear_a: assert property ($fell(overflowFlag) |-> $past(ovfClr))
		else $error("overflow flag dropped");
	cmp_clear_a: assert property ($fell(compareFlag) |-> $past(cmpClr)) else $error("compare flag dropped");
	out_hold_a: assert property (comSh_r == 2'h0 && $past(comSh_r) == 2'h0 |-> $stable(compareOutput))
		else $error("output moved in mode zero");
endmodule
bind tcw_timer8 tcw_timer8_checker chk (.core_clk(core_clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
	.ovfServiced(ovfServiced), .cmpServiced(cmpServiced), .pinIn(pinIn), .pinOut(pinOut),
	.pinOe(pinOe), .overflowFlag(overflowFlag), .compareFlag(compareFlag),
	.compareOutput(compareOutput));
`default_nettype wire

// ==== dv/tcw_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic        core_clk = 1'b0;
	logic        rstn = 1'b0;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [3:0]  adr = 4'h0;
	logic [31:0] dat = 32'h0000_0000;
	logic        ovfSv = 1'b0;
	logic        cmpSv = 1'b0;
	logic        pinIn = 1'b0;
	wire  [31:0] rdat;
	wire         ack;
	wire         pinOut;
	wire         pinOe;
	wire         overflowFlag;
	wire         compareFlag;
	wire         compareOutput;
	logic [31:0] q;
	logic        oc;
	integer      errTotal = 0;
	integer      nCompared = 0;
	integer      i;
	integer      n;
	integer      v;
	always #20 core_clk = ~core_clk;
	tcw_timer8 dut (.core_clk(core_clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.wb_err_o(), .ovfServiced(ovfSv), .cmpServiced(cmpSv), .pinIn(pinIn), .pinOut(pinOut),
		.pinOe(pinOe), .overflowFlag(overflowFlag), .compareFlag(compareFlag),
		.compareOutput(compareOutput));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		nCompared++;
		if (got !== exp) begin
			errTotal++;
			$display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		integer t;
		t = 0;
		@(posedge core_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge core_clk);
			t++;
		end while (ack !== 1'b1 && t < 50);
		if (ack !== 1'b1) begin
			errTotal++;
			$display("CHECK FAILED at %0t: no bus answer", $time);
		end
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	// cycles spanned by k output transitions, after syncing to one
	task automatic gap(input integer k);
		logic   p;
		integer t;
		t = 0;
		n = 0;
		p = compareOutput;
		while (compareOutput === p && t < 600) begin
			@(posedge core_clk);
			t++;
		end
		repeat (k) begin
			p = compareOutput;
			while (compareOutput === p && n < 600) begin
				@(posedge core_clk);
				n++;
			end
		end
	endtask
	task automatic finishTest;
		$display("compared %0d mismatches %0d", nCompared, errTotal);
		if (errTotal == 0 && nCompared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		#(40 * 8000);
		errTotal++;
		finishTest;
	end
	initial begin
		v = $urandom(68);
		repeat (3) @(posedge core_clk);
		rstn <= 1'b1;
		v = $urandom_range(255);
		wb(1, 4'h2, v);
		wb(0, 4'h2, 0);
		chk(q[7:0], v);
		wb(0, 4'h9, 0);
		chk(q, 0);
		// forced matches with timer stopped; mode 0 must leave the output alone
		oc = 1'b0;
		for (i = 0; i < 8; i++) begin
			wb(1, 4'h0, 32'h0000_1000 | ((i % 4) << 4));
			oc = (i % 4 == 1) ? ~oc : (i % 4 == 2) ? 1'b0 : (i % 4 == 3) ? 1'b1 : oc;
			chk(compareOutput, oc);
		end
		wb(1, 4'h0, 0);
		wb(1, 4'h4, 2);
		chk({pinOe, pinOut}, 2);
		wb(1, 4'h0, 32'h0000_0030);
		chk(pinOut, oc);
		v = $urandom_range(1);
		pinIn <= v[0];
		repeat (3) @(posedge core_clk);
		wb(0, 4'h4, 0);
		chk(q[2], v);
		// normal mode: wrap from near max raises overflow
		wb(1, 4'h1, 32'h0000_00FC);
		wb(1, 4'h0, 32'h0000_0100);
		repeat (8) @(posedge core_clk);
		wb(1, 4'h0, 0);
		chk(overflowFlag, 1);
		ovfSv <= 1'b1;
		@(posedge core_clk);
		ovfSv <= 1'b0;
		@(posedge core_clk);
		chk(overflowFlag, 0);
		// clear-on-match toggling: half period is compare plus one
		v = $urandom_range(2, 20);
		wb(1, 4'h2, v);
		wb(1, 4'h1, 0);
		wb(1, 4'h0, 32'h0000_0112);
		gap(2);
		chk(n, 2 * (v + 1));
		chk(compareFlag, 1);
		// prescaled clear-on-match: flag must survive the gap between ticks
		wb(1, 4'h0, 32'h0000_0012);
		wb(1, 4'h3, 3);
		chk(compareFlag, 0);
		wb(1, 4'h0, 32'h0000_0212);
		gap(2);
		chk(n, 16 * (v + 1));
		chk(compareFlag, 1);
		// fast pwm: full period of 256 whatever the polarity
		for (i = 2; i < 4; i++) begin
			wb(1, 4'h0, 32'h0000_0103 | (i << 4));
			gap(2);
			chk(n, 256);
		end
		finishTest;
	end
endmodule
`default_nettype wire
